// >>> verilog/kfra_consts.vh
// constants for the keyed flash region access unit
`ifndef KFRA_CONSTS_VH
`define KFRA_CONSTS_VH

// register offsets, 16-bit register units, high half at the even offset
`define KFRA_OFS_KEY     16'hf168
`define KFRA_OFS_RPTR    16'hf172
`define KFRA_OFS_RDAT    16'hf174
`define KFRA_OFS_ERASE   16'hf17c
`define KFRA_OFS_WPTR    16'hf186
`define KFRA_OFS_WDAT    16'hf188

// region unlock values, and KFRA_KEY_NONE which unlocks no region
`define KFRA_KEY_USER    32'h6615e336
`define KFRA_KEY_CAL     32'h43a24c42
`define KFRA_KEY_NONE    32'h00000000

// flash address layout
`define KFRA_FADDR_W     22
`define KFRA_REGION_BIT  21
`define KFRA_SECT_LSB    12
`define KFRA_CAL_SECT    10'h3c4
`define KFRA_SECT_MASK   32'hfffff000
`define KFRA_WORD_STEP   32'h00000004
`define KFRA_WORD_LSB    2
`define KFRA_BYTE_PAD    2'h0
`define KFRA_HIGH_ZERO   11'h000
`define KFRA_TOP_ZERO    10'h000

// one-hot sequencer states
`define KFRA_ST_IDLE     4'h1
`define KFRA_ST_READ     4'h2
`define KFRA_ST_PROG     4'h4
`define KFRA_ST_ERASE    4'h8

`endif

// >>> verilog/kfra_core.v
// keyed region access unit for the internal 4 MB flash
`timescale 1ns/1ps
`include "kfra_consts.vh"

module kfra_core (
  // clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  // register access from the packet engine
  input  wire [15:0] mb_addr,
  input  wire        mb_wr,
  input  wire        mb_rd,
  input  wire [15:0] mb_wdata,
  input  wire        mb_pkt_end,
  output reg  [15:0] mb_rdata,
  output reg         mb_rvalid,
  output reg         mb_busy,
  // flash macro
  output reg  [21:0] fl_addr,
  output reg  [31:0] fl_wdata,
  output reg         fl_rd,
  output reg         fl_prog,
  output reg         fl_erase,
  input  wire [31:0] fl_rdata,
  input  wire        fl_done
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [31:0] key_r;
  reg  [31:0] rptr_r;
  reg  [31:0] wptr_r;
  reg  [31:0] rbuf_r;
  reg  [15:0] hi_r;
  reg         armed_r;
  reg  [3:0]  state_r;

  wire        idle     = (state_r == `KFRA_ST_IDLE) && !mb_busy;
  wire        lo_half  = mb_addr[0];
  wire [31:0] wd32     = {hi_r, mb_wdata};
  wire [31:0] ers_addr = wd32 & `KFRA_SECT_MASK;

  wire sel_key  = ({mb_addr[15:1], 1'h0} == `KFRA_OFS_KEY);
  wire sel_rptr = ({mb_addr[15:1], 1'h0} == `KFRA_OFS_RPTR);
  wire sel_rdat = ({mb_addr[15:1], 1'h0} == `KFRA_OFS_RDAT);
  wire sel_ers  = ({mb_addr[15:1], 1'h0} == `KFRA_OFS_ERASE);
  wire sel_wptr = ({mb_addr[15:1], 1'h0} == `KFRA_OFS_WPTR);
  wire sel_wdat = ({mb_addr[15:1], 1'h0} == `KFRA_OFS_WDAT);

  // ---------------------------------------------------------------
  // region permission
  // ---------------------------------------------------------------
  // key selects region
  function perm;
    input [31:0] key;
    input [31:0] addr;
    begin
      perm = ((key == `KFRA_KEY_USER) &&
              (addr[31:`KFRA_REGION_BIT] == `KFRA_HIGH_ZERO)) ||
             ((key == `KFRA_KEY_CAL) &&
              (addr[31:`KFRA_FADDR_W] == `KFRA_TOP_ZERO) &&
              (addr[`KFRA_REGION_BIT:`KFRA_SECT_LSB] == `KFRA_CAL_SECT));
    end
  endfunction

  // ---------------------------------------------------------------
  // readback of plain registers
  // ---------------------------------------------------------------
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (sel_key)
      rd_word = key_r;
    else if (sel_rptr)
      rd_word = rptr_r;
    else if (sel_wptr)
      rd_word = wptr_r;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      key_r     <= `KFRA_KEY_NONE;
      rptr_r    <= 32'h00000000;
      wptr_r    <= 32'h00000000;
      rbuf_r    <= 32'h00000000;
      hi_r      <= 16'h0000;
      armed_r   <= 1'b0;
      state_r   <= `KFRA_ST_IDLE;
      mb_rdata  <= 16'h0000;
      mb_rvalid <= 1'b0;
      mb_busy   <= 1'b0;
      fl_addr   <= 22'h000000;
      fl_wdata  <= 32'h00000000;
      fl_rd     <= 1'b0;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b0;
    end else begin
      mb_rvalid <= 1'b0;
      fl_rd     <= 1'b0;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b0;

      if (mb_pkt_end) begin
        key_r   <= `KFRA_KEY_NONE;
        armed_r <= 1'b0;
      end

      case (state_r)
        `KFRA_ST_IDLE: begin
          if (idle && mb_wr && !lo_half) begin
            hi_r <= mb_wdata;
          end else if (idle && mb_wr) begin
            if (sel_key) begin
              key_r   <= wd32;
              armed_r <= 1'b0;
            end
            if (sel_rptr)
              rptr_r <= wd32;
            if (sel_wptr) begin
              wptr_r  <= wd32;
              armed_r <= (key_r != `KFRA_KEY_NONE);
            end
            if (sel_wdat) begin
              if (armed_r && perm(key_r, wptr_r)) begin
                fl_addr  <= {wptr_r[`KFRA_FADDR_W-1:`KFRA_WORD_LSB], `KFRA_BYTE_PAD};
                fl_wdata <= wd32;
                fl_prog  <= 1'b1;
                mb_busy  <= 1'b1;
                state_r  <= `KFRA_ST_PROG;
              end else begin
                wptr_r <= wptr_r + `KFRA_WORD_STEP;
              end
            end
            if (sel_ers && perm(key_r, ers_addr)) begin
              fl_addr  <= ers_addr[`KFRA_FADDR_W-1:0];
              fl_erase <= 1'b1;
              mb_busy  <= 1'b1;
              state_r  <= `KFRA_ST_ERASE;
            end
          end else if (idle && mb_rd) begin
            if (sel_rdat && !lo_half) begin
              fl_addr <= {rptr_r[`KFRA_FADDR_W-1:`KFRA_WORD_LSB], `KFRA_BYTE_PAD};
              fl_rd   <= 1'b1;
              mb_busy <= 1'b1;
              state_r <= `KFRA_ST_READ;
            end else if (sel_rdat) begin
              mb_rdata  <= rbuf_r[15:0];
              mb_rvalid <= 1'b1;
              rptr_r    <= rptr_r + `KFRA_WORD_STEP;
            end else begin
              mb_rdata  <= lo_half ? rd_word[15:0] : rd_word[31:16];
              mb_rvalid <= 1'b1;
            end
          end
        end
        `KFRA_ST_READ: begin
          if (fl_done) begin
            rbuf_r    <= fl_rdata;
            mb_rdata  <= fl_rdata[31:16];
            mb_rvalid <= 1'b1;
            mb_busy   <= 1'b0;
            state_r   <= `KFRA_ST_IDLE;
          end
        end
        `KFRA_ST_PROG: begin
          if (fl_done) begin
            wptr_r  <= wptr_r + `KFRA_WORD_STEP;
            mb_busy <= 1'b0;
            state_r <= `KFRA_ST_IDLE;
          end
        end
        `KFRA_ST_ERASE: begin
          if (fl_done) begin
            mb_busy <= 1'b0;
            state_r <= `KFRA_ST_IDLE;
          end
        end
        default: begin
          mb_busy <= 1'b0;
          state_r <= `KFRA_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> dv/kfra_core_sva.sv
// port checks for the flash access unit
`timescale 1ns/1ps
`include "kfra_consts.vh"
module kfra_core_sva (
  // clock and reset
  input wire        sys_clk,
  input wire        arst_n,
  // register side
  input wire [15:0] mb_addr,
  input wire        mb_rd,
  input wire        mb_rvalid,
  input wire        mb_busy,
  // flash side
  input wire [21:0] fl_addr,
  input wire        fl_rd,
  input wire        fl_prog,
  input wire        fl_erase,
  input wire        fl_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire go = fl_rd | fl_prog | fl_erase;
  wire rd_ok = mb_rd & !mb_busy;
  a_read_launch: assert property (rd_ok && mb_addr == `KFRA_OFS_RDAT |=> fl_rd && mb_busy)
    else $error("window read did not start flash");
  a_word_align: assert property (fl_rd || fl_prog |-> fl_addr[1:0] == 2'h0)
    else $error("flash word address unaligned");
  a_erase_align: assert property (fl_erase |-> fl_addr[11:0] == 12'h000)
    else $error("erase address not on sector");
  a_region_guard: assert property (fl_prog || fl_erase |->
    !fl_addr[21] || fl_addr[21:12] == `KFRA_CAL_SECT)
    else $error("change outside permitted region");
  a_busy_hold: assert property (mb_busy && !fl_done |=> mb_busy)
    else $error("busy dropped early");
  a_busy_release: assert property (mb_busy && fl_done |=> !mb_busy)
    else $error("busy not released");
  a_start_pulse: assert property (go |-> mb_busy ##1 !go)
    else $error("flash start not a single pulse");
  a_plain_answer: assert property (rd_ok && mb_addr == `KFRA_OFS_KEY |=> mb_rvalid && !fl_rd)
    else $error("key read not answered");
  c_erase: cover property (fl_erase);
  c_prog: cover property (fl_prog);
  c_read: cover property (fl_rd ##1 fl_done);
endmodule
bind kfra_core kfra_core_sva u_sva (.sys_clk(sys_clk), .arst_n(arst_n), .mb_addr(mb_addr),
  .mb_rd(mb_rd), .mb_rvalid(mb_rvalid), .mb_busy(mb_busy), .fl_addr(fl_addr), .fl_rd(fl_rd),
  .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_done(fl_done));

// >>> dv/kfra_core_tb.sv
// self-checking bench for the flash access unit
`timescale 1ns/1ps
`include "kfra_consts.vh"
`define CHK(n,e,s) begin total_checks++; if ((e) !== (s)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module kfra_core_tb;
  logic        sys_clk, arst_n, mb_wr, mb_rd, mb_pkt_end, fl_done, mb_rvalid, mb_busy;
  logic        fl_rd, fl_prog, fl_erase;
  logic [15:0] mb_addr, mb_wdata, mb_rdata;
  logic [21:0] fl_addr, last_er;
  logic [31:0] fl_wdata, fl_rdata, v, base, d0, d1;
  logic [31:0] mem [int];
  int          num_errors, total_checks, n_er;
  kfra_core uut (.sys_clk(sys_clk), .arst_n(arst_n), .mb_addr(mb_addr), .mb_wr(mb_wr),
    .mb_rd(mb_rd), .mb_wdata(mb_wdata), .mb_pkt_end(mb_pkt_end), .mb_rdata(mb_rdata),
    .mb_rvalid(mb_rvalid), .mb_busy(mb_busy), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_rd(fl_rd), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_rdata(fl_rdata),
    .fl_done(fl_done));
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] peek(int a);
    return mem.exists(a) ? mem[a] : 32'hffffffff;
  endfunction
  function automatic logic [21:0] sect_base(logic [31:0] a);
    return a[21:0] & 22'h3ff000;
  endfunction
  // ----
  // flash stand-in, done one cycle after each start
  // ----
  always @(negedge sys_clk) begin
    fl_done <= fl_rd | fl_prog | fl_erase;
    fl_rdata <= peek(fl_addr[21:2]);
    if (fl_prog) mem[fl_addr[21:2]] = peek(fl_addr[21:2]) & fl_wdata;
    if (fl_erase) begin
      n_er++;
      last_er = fl_addr;
      for (int i = 0; i < 1024; i++) mem[fl_addr[21:2] + i] = 32'hffffffff;
    end
  end
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    int n;
    @(negedge sys_clk) {mb_wr, mb_rd, mb_addr, mb_wdata} = {w, !w, a, d};
    @(negedge sys_clk) {mb_wr, mb_rd} = 2'h0;
    for (n = 0; n < 50 && (w ? mb_busy : !mb_rvalid); n++) @(negedge sys_clk);
    if (n == 50) begin
      num_errors++;
      stop_test;
    end
  endtask
  task automatic w32(input logic [15:0] a, input logic [31:0] d);
    acc(1, a, d[31:16]);
    acc(1, a + 16'h1, d[15:0]);
  endtask
  task automatic r32(input logic [15:0] a);
    acc(0, a, 16'h0);
    v[31:16] = mb_rdata;
    acc(0, a + 16'h1, 16'h0);
    v[15:0] = mb_rdata;
  endtask
  task automatic pend;
    @(negedge sys_clk) mb_pkt_end = 1;
    @(negedge sys_clk) mb_pkt_end = 0;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000 num_errors++;
    stop_test;
  end
  initial begin
    {mb_wr, mb_rd, mb_pkt_end, arst_n} = 4'h0;
    {mb_addr, mb_wdata} = 32'h0;
    v = $urandom(64508);
    repeat (20) @(negedge sys_clk);
    arst_n = 1;
    w32(`KFRA_OFS_KEY, `KFRA_KEY_USER);
    r32(`KFRA_OFS_KEY);
    `CHK("key", `KFRA_KEY_USER, v)
    pend;
    r32(`KFRA_OFS_KEY);
    `CHK("key clear", 32'h0, v)
    for (int k = 0; k < 5; k++) begin
      base = (k == 0) ? 32'h001ffff8 : $urandom & 32'h001ffff8;
      {d0, d1} = {$urandom, $urandom};
      w32(`KFRA_OFS_KEY, `KFRA_KEY_USER);
      w32(`KFRA_OFS_ERASE, base | 32'h3);
      pend;
      `CHK("erase addr", sect_base(base), last_er)
      w32(`KFRA_OFS_KEY, `KFRA_KEY_USER);
      w32(`KFRA_OFS_WPTR, base);
      w32(`KFRA_OFS_WDAT, d0);
      w32(`KFRA_OFS_WDAT, d1);
      pend;
      w32(`KFRA_OFS_WPTR, base);
      w32(`KFRA_OFS_WDAT, 32'h0);
      w32(`KFRA_OFS_RPTR, base | k[1:0]);
      r32(`KFRA_OFS_RDAT);
      `CHK("word 0", d0, v)
      r32(`KFRA_OFS_RDAT);
      `CHK("word 1", d1, v)
      r32(`KFRA_OFS_RPTR);
      `CHK("read ptr", (base + 32'h8) | k[1:0], v)
      r32(`KFRA_OFS_WPTR);
      `CHK("write ptr", base + 32'h4, v)
    end
    n_er = 0;
    w32(`KFRA_OFS_KEY, `KFRA_KEY_CAL);
    w32(`KFRA_OFS_ERASE, 32'h00001000);
    pend;
    `CHK("wrong key", 0, n_er)
    w32(`KFRA_OFS_KEY, `KFRA_KEY_CAL);
    w32(`KFRA_OFS_ERASE, 32'h003c4abc);
    pend;
    `CHK("cal erase", 22'h3c4000, last_er)
    stop_test;
  end
endmodule
